/* shared/srs_pkg.sv */
// Purpose: Shared constants and types of the sync reference selector
// Assumes: 100 MHz system clock, classic Wishbone register bus
// Notes: Quality codes, register map, field layout and timing counts
package srs_pkg;

   // Bus shape
   localparam int SRS_AW = 8;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [SRS_AW-1:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } srs_wb_req_s;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } srs_wb_rsp_s;

   // Register offsets (byte addresses)
   localparam logic [SRS_AW-1:0] SRS_ADR_MASK = 8'hfc;
   localparam logic [SRS_AW-1:0] SRS_CTRL_OFS = 8'h00;
   localparam logic [SRS_AW-1:0] SRS_FAC_OFS = 8'h04;
   localparam logic [SRS_AW-1:0] SRS_NEREF_OFS = 8'h08;
   localparam logic [SRS_AW-1:0] SRS_OUTREF_OFS = 8'h0c;
   localparam logic [SRS_AW-1:0] SRS_REVT_OFS = 8'h10;
   localparam logic [SRS_AW-1:0] SRS_STAT_OFS = 8'h14;

   // Field positions
   localparam int SRS_CTRL_MODE_LSB = 0;
   localparam int SRS_CTRL_REV_BIT = 2;
   localparam int SRS_CTRL_INS_LSB = 3;
   localparam int SRS_FAC_SIG_LSB = 0;
   localparam int SRS_FAC_HDB3_BIT = 2;
   localparam int SRS_FAC_FRM_LSB = 3;
   localparam int SRS_FAC_SSM_BIT = 6;
   localparam int SRS_FAC_SA_LSB = 7;
   localparam int SRS_FAC_THR_LSB = 10;
   localparam int SRS_REF_W = 4;
   localparam int SRS_ST_SRC_LSB = 0;
   localparam int SRS_ST_OWN_LSB = 4;
   localparam int SRS_ST_AIS_LSB = 8;
   localparam int SRS_ST_PEND_BIT = 10;
   localparam int SRS_ST_CUR_LSB = 11;
   localparam int SRS_ST_OK_LSB = 16;
   localparam int SRS_S1_QL_MSB = 3;
   localparam logic [3:0] SRS_S1_SPARE = 4'h0;

   // Modes and facility settings
   typedef enum logic [1:0] {
      SRS_EXT = 2'h0,
      SRS_LINE = 2'h1,
      SRS_MIXED = 2'h2
   } srs_mode_e;
   typedef enum logic [1:0] {
      SRS_SIG_E1 = 2'h0,
      SRS_SIG_2M = 2'h1,
      SRS_SIG_64K = 2'h2
   } srs_sig_e;
   localparam logic [2:0] SRS_FRM_UNF = 3'h0;
   localparam logic [2:0] SRS_FRM_CAS = 3'h2;
   localparam logic [2:0] SRS_FRM_CASCRC = 3'h4;
   localparam logic [2:0] SRS_SA4 = 3'h0;
   localparam logic [2:0] SRS_SA8 = 3'h4;
   typedef struct packed {
      logic [1:0] sig;
      logic hdb3;
      logic [2:0] frm;
      logic ssm;
      logic [2:0] sa;
   } srs_fac_s;

   // Quality codes in code order, then their ranks, best first
   localparam logic [3:0] SRS_QL_STU = 4'h0;
   localparam logic [3:0] SRS_QL_PRC = 4'h2;
   localparam logic [3:0] SRS_QL_SSUA = 4'h4;
   localparam logic [3:0] SRS_QL_SSUB = 4'h8;
   localparam logic [3:0] SRS_QL_SETS = 4'hb;
   localparam logic [3:0] SRS_QL_DNU = 4'hf;
   localparam logic [2:0] SRS_RK_PRC = 3'h0;
   localparam logic [2:0] SRS_RK_STU = 3'h1;
   localparam logic [2:0] SRS_RK_SSUA = 3'h2;
   localparam logic [2:0] SRS_RK_SSUB = 3'h3;
   localparam logic [2:0] SRS_RK_SETS = 3'h4;
   localparam logic [2:0] SRS_RK_DNU = 3'h5;
   localparam logic [2:0] SRS_RK_BAD = 3'h6;
   localparam logic [2:0] SRS_RK_NONE = 3'h7;

   // Source numbering
   localparam int SRS_NSRC_MAX = 16;
   localparam logic [3:0] SRS_SRC_INT = 4'h0;
   localparam logic [3:0] SRS_SRC_LN0 = 4'h3;
   localparam logic [1:0] SRS_HOLD = 2'h3;

   // Timing
   localparam int SRS_CLK_HZ = 100000000;
   localparam int SRS_CLK_NS = 10;
   localparam int SRS_LOS_NS = 1000;
   localparam logic [7:0] SRS_LOS_CYC = 8'(SRS_LOS_NS / SRS_CLK_NS);
   localparam int SRS_REV_UNIT_S = 1;
   localparam int SRS_TICK_CYC = SRS_REV_UNIT_S * SRS_CLK_HZ;

   // Reset values
   localparam logic [15:0] SRS_REVT_RST = 16'h012c;
   localparam logic [3:0] SRS_THR_RST = 4'hf;

endpackage : srs_pkg

/* hw/srs_ql_rank.sv */
// Purpose: Map a four-bit quality code to its rank
// Assumes: Code taken from S1 bits 5 to 8 or the chosen Sa bit nibble
// Notes: Reserved and do-not-use codes rank as unusable
`timescale 1ns/1ps
module srs_ql_rank (
   // Code in
   input wire logic [3:0] ql,
   // Rank out
   output logic [2:0] rank,
   output logic usable
);
   import srs_pkg::*;

   // Rank lookup, best quality lowest
   always_comb begin
      case (ql)
         SRS_QL_PRC: rank = SRS_RK_PRC;
         SRS_QL_STU: rank = SRS_RK_STU;
         SRS_QL_SSUA: rank = SRS_RK_SSUA;
         SRS_QL_SSUB: rank = SRS_RK_SSUB;
         SRS_QL_SETS: rank = SRS_RK_SETS;
         SRS_QL_DNU: rank = SRS_RK_DNU;
         default: rank = SRS_RK_BAD;
      endcase
      usable = rank < SRS_RK_DNU;
   end

endmodule : srs_ql_rank

/* hw/srs_top.sv */
// Purpose: Timing reference selector with quality messaging
// Assumes: Link clocks and quality nibbles are asynchronous pins
// Notes: Sources 0 internal, 1-2 building inputs, 3 on line ports
//
// Functional notes
// - quality code sits in S1 bits 5-8
// - pick best reference, avoid timing loops
// - rank G811, STU, G812T, G812L, SETS, DUS
// - code 0000 means quality unknown
// - 0010 is G.811; unlisted codes reserved
// - code 0100 is SSU type A
// - code 1000 is SSU type B
// - code 1011 is SETS
// - code 1111 never used for timing
// - Sa nibble uses same codes as S1
// - external, line and mixed timing modes
// - revertive mode returns to primary reference
// - revert waits configurable time first
// - each building input has in-service state
// - five framings, ignored in clock modes
// - quality messaging enabled, off in clock modes
// - one Sa bit Sa4-Sa8 carries quality
// - AIS on outputs at or below threshold
// - threshold used only without messaging or CRC
// - reference 1, then 2, then 3
// - offered references depend on timing mode
// - six output reference entries feed outputs
// - output active once its input in service
// - no line timing with 64 KHz inputs
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps
module srs_top #(
   parameter int N_LINE = 2,
   parameter int TICK_CYCLES = srs_pkg::SRS_TICK_CYC
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Register bus
   input wire srs_pkg::srs_wb_req_s WB_REQ,
   output srs_pkg::srs_wb_rsp_s WB_RSP,
   // Building timing inputs
   input wire logic [1:0] BT_CLK,
   input wire logic [1:0][3:0] BT_QL,
   // Optical line ports
   input wire logic [N_LINE-1:0] LN_CLK,
   input wire logic [N_LINE-1:0][7:0] LN_S1,
   output logic [N_LINE-1:0][7:0] TX_S1,
   // Timing outputs
   output logic [1:0] OUT_ACTIVE,
   output logic [1:0] OUT_AIS,
   output logic [1:0][3:0] OUT_SRC,
   output logic [3:0] OUT_QL,
   // Status and facility setup
   output logic [3:0] ACT_SRC,
   output srs_pkg::srs_fac_s FAC_CFG
);
   import srs_pkg::*;

   localparam int NL = 2 + N_LINE;
   localparam int NS = 1 + NL;

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      srs_mode_e mode;
      logic rev;
      logic [1:0] ins;
      srs_fac_s cfg;
      srs_fac_s fac;
      logic [3:0] thr;
      logic [3*SRS_REF_W-1:0] neref;
      logic [6*SRS_REF_W-1:0] outref;
      logic [15:0] rev_time;
      logic [NL-1:0] s1;
      logic [NL-1:0] s2;
      logic [NL-1:0] s3;
      logic [NL-1:0][3:0] q1;
      logic [NL-1:0][3:0] q2;
      logic [NL-1:0][3:0] q3;
      logic [NL-1:0][3:0] qs;
      logic [NL-1:0][7:0] los;
      logic [31:0] tick;
      logic [1:0] cur;
      logic pend;
      logic [1:0] tgt;
      logic [15:0] rcnt;
      logic [3:0] src;
      logic [3:0] own;
      logic [1:0] act;
      logic [1:0] ais;
      logic [1:0][3:0] osrc;
      logic [N_LINE-1:0][7:0] tx;
   } srs_state_s;

   srs_state_s st;
   srs_state_s next_st;

   logic [NL-1:0] lk;
   logic [NL-1:0][3:0] lq;
   logic [15:0][3:0] ql16;
   logic [15:0][2:0] rk16;
   logic [15:0] use16;
   logic [15:0] ok16;
   logic [2:0] thr_rk;
   logic ssm_rx;
   logic thr_app;
   logic cur_ok;
   logic better;
   logic hit;
   logic [1:0] best;
   logic [2:0] brk;
   logic [2:0] crk;
   logic [1:0] have;

   // Raw pins gathered per sampled link
   assign lk = {LN_CLK, BT_CLK};
   for (genvar j = 0; j < NL; j++) begin : g_lq
      if (j < 2) begin : g_bt
         assign lq[j] = BT_QL[j];
      end else begin : g_ln
         assign lq[j] = LN_S1[j-2][SRS_S1_QL_MSB:0];
      end
   end

   // Building-input quality only trusted with framed messaging; line ports always use received quality
   assign ssm_rx = st.fac.ssm && st.fac.frm != SRS_FRM_UNF;
   // Threshold in force without messaging or CRC framing
   assign thr_app = !st.fac.ssm || st.fac.frm <= SRS_FRM_CAS;

   // Per source quality, availability and health
   for (genvar i = 0; i < SRS_NSRC_MAX; i++) begin : g_src
      logic allow;
      logic alive;
      if (i == 0) begin : g_int
         assign ql16[i] = SRS_QL_SETS;
         assign allow = 1'b1;
         assign alive = 1'b1;
      end else if (i < 3) begin : g_bt
         assign ql16[i] = ssm_rx ? st.qs[i-1] : SRS_QL_STU;
         assign allow = st.mode != SRS_LINE && st.ins[i-1];
         assign alive = st.los[i-1] < SRS_LOS_CYC;
      end else if (i < NS) begin : g_ln
         assign ql16[i] = st.qs[i-1];
         assign allow = st.mode != SRS_EXT &&
            st.cfg.sig != SRS_SIG_64K;
         assign alive = st.los[i-1] < SRS_LOS_CYC;
      end else begin : g_pad
         assign ql16[i] = SRS_QL_DNU;
         assign allow = 1'b0;
         assign alive = 1'b0;
      end
      srs_ql_rank u_rank (
         .ql(ql16[i]),
         .rank(rk16[i]),
         .usable(use16[i])
      );
      assign ok16[i] = allow && alive && use16[i];
   end

   // Rank of the AIS threshold code
   srs_ql_rank u_thr (
      .ql(st.thr),
      .rank(thr_rk),
      .usable()
   );

   // Next state: bus, sampling, selection and outputs
   always_comb begin
      logic [31:0] rd;
      logic [31:0] w;
      logic [3:0] idx;
      logic [SRS_AW-1:0] adr;
      rd = '0;
      w = '0;
      idx = '0;
      adr = WB_REQ.adr & SRS_ADR_MASK;
      next_st = st;
      best = SRS_HOLD;
      brk = SRS_RK_NONE;
      crk = SRS_RK_NONE;
      cur_ok = 1'b0;
      have = '0;

      // Register readback
      case (adr)
         SRS_CTRL_OFS: begin
            rd[SRS_CTRL_MODE_LSB +: 2] = st.mode;
            rd[SRS_CTRL_REV_BIT] = st.rev;
            rd[SRS_CTRL_INS_LSB +: 2] = st.ins;
         end
         SRS_FAC_OFS: begin
            rd[SRS_FAC_SIG_LSB +: 2] = st.cfg.sig;
            rd[SRS_FAC_HDB3_BIT] = st.cfg.hdb3;
            rd[SRS_FAC_FRM_LSB +: 3] = st.cfg.frm;
            rd[SRS_FAC_SSM_BIT] = st.cfg.ssm;
            rd[SRS_FAC_SA_LSB +: 3] = st.cfg.sa;
            rd[SRS_FAC_THR_LSB +: 4] = st.thr;
         end
         SRS_NEREF_OFS: rd[3*SRS_REF_W-1:0] = st.neref;
         SRS_OUTREF_OFS: rd[6*SRS_REF_W-1:0] = st.outref;
         SRS_REVT_OFS: rd[15:0] = st.rev_time;
         SRS_STAT_OFS: begin
            rd[SRS_ST_SRC_LSB +: 4] = st.src;
            rd[SRS_ST_OWN_LSB +: 4] = st.own;
            rd[SRS_ST_AIS_LSB +: 2] = st.ais;
            rd[SRS_ST_PEND_BIT] = st.pend;
            rd[SRS_ST_CUR_LSB +: 2] = st.cur;
            rd[SRS_ST_OK_LSB +: SRS_NSRC_MAX] = ok16;
         end
         default: rd = '0;
      endcase

      // Byte lane merge and single-cycle acknowledge
      for (int k = 0; k < 4; k++) begin
         w[k*8 +: 8] = WB_REQ.sel[k] ? WB_REQ.dat[k*8 +: 8] : rd[k*8 +: 8];
      end
      next_st.ack = WB_REQ.cyc && WB_REQ.stb && !st.ack;
      next_st.rdat = rd;
      if (next_st.ack && WB_REQ.we) begin
         case (adr)
            SRS_CTRL_OFS: begin
               next_st.mode = srs_mode_e'(w[SRS_CTRL_MODE_LSB +: 2]);
               next_st.rev = w[SRS_CTRL_REV_BIT];
               next_st.ins = w[SRS_CTRL_INS_LSB +: 2];
            end
            SRS_FAC_OFS: begin
               next_st.cfg.sig = w[SRS_FAC_SIG_LSB +: 2];
               next_st.cfg.hdb3 = w[SRS_FAC_HDB3_BIT];
               next_st.cfg.frm = w[SRS_FAC_FRM_LSB +: 3];
               next_st.cfg.ssm = w[SRS_FAC_SSM_BIT];
               next_st.cfg.sa = w[SRS_FAC_SA_LSB +: 3];
               next_st.thr = w[SRS_FAC_THR_LSB +: 4];
            end
            SRS_NEREF_OFS: next_st.neref = w[3*SRS_REF_W-1:0];
            SRS_OUTREF_OFS: next_st.outref = w[6*SRS_REF_W-1:0];
            SRS_REVT_OFS: next_st.rev_time = w[15:0];
            default: next_st.rev_time = st.rev_time;
         endcase
      end

      // Facility setup as applied; clock modes mask E1 options
      next_st.fac = st.cfg;
      if (st.cfg.sa > SRS_SA8) begin
         next_st.fac.sa = SRS_SA4;
      end
      if (st.cfg.sig != SRS_SIG_E1) begin
         next_st.fac.hdb3 = 1'b0;
         next_st.fac.frm = SRS_FRM_UNF;
         next_st.fac.ssm = 1'b0;
         next_st.fac.sa = SRS_SA4;
      end
      if (st.cfg.frm > SRS_FRM_CASCRC) begin
         next_st.fac.frm = SRS_FRM_UNF;
      end

      // Two-stage sampling of link pins, edges watched
      next_st.s1 = lk;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.q1 = lq;
      next_st.q2 = st.q1;
      next_st.q3 = st.q2;
      for (int k = 0; k < NL; k++) begin
         // Quality word taken only once steady, pin bits may skew
         if (st.q2[k] == st.q3[k]) begin
            next_st.qs[k] = st.q2[k];
         end
         if (st.s2[k] != st.s3[k]) begin
            next_st.los[k] = '0;
         end else if (st.los[k] != SRS_LOS_CYC) begin
            next_st.los[k] = st.los[k] + 8'h01;
         end
      end

      // Revert time base
      hit = st.tick == 32'(TICK_CYCLES - 1);
      next_st.tick = hit ? '0 : st.tick + 32'h1;

      // Best healthy reference, ties to the earlier entry
      for (int r = 0; r < 3; r++) begin
         idx = st.neref[r*SRS_REF_W +: SRS_REF_W];
         if (ok16[idx] && rk16[idx] < brk) begin
            best = 2'(r);
            brk = rk16[idx];
         end
      end
      if (st.cur != SRS_HOLD) begin
         idx = st.neref[st.cur*SRS_REF_W +: SRS_REF_W];
         cur_ok = ok16[idx];
         crk = rk16[idx];
      end
      better = best != st.cur &&
         (brk < crk || (brk == crk && best < st.cur));

      // Switch at once on failure, revert only after the wait
      if (!cur_ok) begin
         next_st.cur = best;
         next_st.pend = 1'b0;
         next_st.rcnt = '0;
      end else if (better && st.rev) begin
         if (!st.pend || st.tgt != best) begin
            next_st.pend = 1'b1;
            next_st.tgt = best;
            next_st.rcnt = '0;
         end else if (st.rcnt >= st.rev_time) begin
            next_st.cur = best;
            next_st.pend = 1'b0;
         end else if (hit) begin
            next_st.rcnt = st.rcnt + 16'h1;
         end
      end else begin
         next_st.pend = 1'b0;
      end
      next_st.src = st.cur == SRS_HOLD ? SRS_SRC_INT :
         st.neref[st.cur*SRS_REF_W +: SRS_REF_W];
      next_st.own = ql16[st.src];

      // Output references: first healthy of three per output
      for (int o = 0; o < 2; o++) begin
         next_st.osrc[o] = SRS_SRC_INT;
         for (int e = 2; e >= 0; e--) begin
            idx = st.outref[(o*3+e)*SRS_REF_W +: SRS_REF_W];
            if (ok16[idx]) begin
               next_st.osrc[o] = idx;
               have[o] = 1'b1;
            end
         end
         next_st.act[o] = st.ins[o];
         next_st.ais[o] = st.ins[o] && (!have[o] ||
            (thr_app && rk16[st.src] >= thr_rk));
      end

      // Outgoing S1: do-not-use back toward our own source
      for (int k = 0; k < N_LINE; k++) begin
         next_st.tx[k] = {SRS_S1_SPARE,
            (st.src == SRS_SRC_LN0 + 4'(k)) ?
            SRS_QL_DNU : st.own};
      end
   end

   // State register
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         st <= '0;
         st.rev <= 1'b1;
         st.cfg.hdb3 <= 1'b1;
         st.cfg.frm <= SRS_FRM_CASCRC;
         st.cfg.ssm <= 1'b1;
         st.fac.hdb3 <= 1'b1;
         st.fac.frm <= SRS_FRM_CASCRC;
         st.fac.ssm <= 1'b1;
         st.thr <= SRS_THR_RST;
         st.rev_time <= SRS_REVT_RST;
         st.los <= {NL{SRS_LOS_CYC}};
         st.cur <= SRS_HOLD;
         st.own <= SRS_QL_SETS;
         for (int k = 0; k < N_LINE; k++) begin
            st.tx[k] <= {SRS_S1_SPARE, SRS_QL_SETS};
         end
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state
   assign WB_RSP.ack = st.ack;
   assign WB_RSP.dat = st.rdat;
   assign TX_S1 = st.tx;
   assign OUT_ACTIVE = st.act;
   assign OUT_AIS = st.ais;
   assign OUT_SRC = st.osrc;
   assign OUT_QL = st.own;
   assign ACT_SRC = st.src;
   assign FAC_CFG = st.fac;

   // Checks
   AST_FAIL_MOVE:
   assert property (@(posedge CLK) disable iff (RESET)
      !cur_ok |=> st.cur == $past(best))
      else $error("failed reference not left");
   AST_NO_REVERT:
   assert property (@(posedge CLK) disable iff (RESET)
      (cur_ok && !st.rev) |=> $stable(st.cur))
      else $error("switched on healthy reference");
   AST_REV_WAIT:
   assert property (@(posedge CLK) disable iff (RESET)
      (cur_ok && st.pend && st.rcnt < st.rev_time) |=> $stable(st.cur))
      else $error("reverted before wait ended");
   AST_CANCEL:
   assert property (@(posedge CLK) disable iff (RESET)
      (cur_ok && !better) |=> !st.pend)
      else $error("revert wait not cancelled");
   AST_AIS_ON:
   assert property (@(posedge CLK) disable iff (RESET)
      (st.ins[0] && thr_app && rk16[st.src] >= thr_rk) |=> OUT_AIS[0])
      else $error("AIS missing at threshold");
   AST_AIS_OFF:
   assert property (@(posedge CLK) disable iff (RESET)
      (st.ins[0] && have[0] && !thr_app) |=> !OUT_AIS[0])
      else $error("AIS with threshold out of force");
   AST_OUT_ON:
   assert property (@(posedge CLK) disable iff (RESET)
      $rose(st.ins[1]) |=> OUT_ACTIVE[1] ##1 OUT_ACTIVE[1] || !st.ins[1])
      else $error("output not active in service");
   AST_LOOP:
   assert property (@(posedge CLK) disable iff (RESET)
      st.src == SRS_SRC_LN0 |=> TX_S1[0][SRS_S1_QL_MSB:0] == SRS_QL_DNU)
      else $error("quality echoed to source port");
   AST_NO_64K_LINE:
   assert property (@(posedge CLK) disable iff (RESET)
      st.cfg.sig == SRS_SIG_64K |-> !ok16[SRS_SRC_LN0])
      else $error("line source offered with 64k");
   AST_DNU:
   assert property (@(posedge CLK) disable iff (RESET)
      ql16[1] == SRS_QL_DNU |-> !ok16[1])
      else $error("do-not-use source healthy");
   AST_SA_MASK:
   assert property (@(posedge CLK) disable iff (RESET)
      st.cfg.sig != SRS_SIG_E1 |=> FAC_CFG.sa == SRS_SA4 && !FAC_CFG.ssm)
      else $error("Sa choice applied in clock mode");

endmodule : srs_top

/* tb/srs_partner.sv */
// Purpose: Timing supplies on the far side of the reference selector
// Assumes: One shared 125 ns link timebase, gated per source
// Notes: A disabled source stops its clock and shows inverted quality
`timescale 1ns/1ps
module srs_partner (
   // Source control from the bench
   input wire logic [3:0] en,
   input wire logic [3:0][3:0] ql,
   // Pins toward the selector
   output logic [1:0] bt_clk,
   output logic [1:0][3:0] bt_ql,
   output logic [1:0] ln_clk,
   output logic [1:0][7:0] ln_s1
);
   logic lclk = 1'b0;

   // Link timebase, phase unrelated to the system clock
   initial begin
      #3.3;
      forever #62.5 lclk = ~lclk;
   end

   // Clocks stand still and quality shows inverted while disabled
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         bt_clk[i] = lclk & en[i];
         ln_clk[i] = lclk & en[i+2];
         bt_ql[i] = en[i] ? ql[i] : ~ql[i];
         ln_s1[i][7:4] = ~ql[i+2];
         ln_s1[i][3:0] = en[i+2] ? ql[i+2] : ~ql[i+2];
      end
   end
endmodule : srs_partner

/* tb/tb_top.sv */
// Purpose: Self-checking bench of the sync reference selector
// Assumes: Ten-cycle revert tick, two line ports
// Notes: Random quality codes from a fixed seed
`timescale 1ns/1ps
module tb_top;
   import srs_pkg::*;
   localparam logic [15:0] FV [6] = '{16'h0024, 16'h1024, 16'h0864,
      16'h0854, 16'h0044, 16'h085c};
   localparam logic [1:0] AV [6] = '{2'h3, 2'h0, 2'h0, 2'h3, 2'h3, 2'h0};
   localparam logic [3:0] MV [3] = '{4'h1, 4'h3, 4'h3};
   logic clk;
   logic rst;
   srs_wb_req_s req;
   srs_wb_rsp_s rsp;
   logic [3:0] en;
   logic [3:0][3:0] ql;
   logic [1:0] bt_clk, ln_clk, out_active, out_ais;
   logic [1:0][3:0] bt_ql, out_src;
   logic [1:0][7:0] ln_s1, tx_s1;
   logic [3:0] out_ql, act_src, a, b, e, o;
   srs_fac_s fac_cfg;
   logic [31:0] q, f;
   int fail_count, compares;

   srs_top #(.N_LINE(2), .TICK_CYCLES(10)) i_srs_top (.CLK(clk), .RESET(rst),
      .WB_REQ(req), .WB_RSP(rsp), .BT_CLK(bt_clk), .BT_QL(bt_ql),
      .LN_CLK(ln_clk), .LN_S1(ln_s1), .TX_S1(tx_s1),
      .OUT_ACTIVE(out_active), .OUT_AIS(out_ais), .OUT_SRC(out_src),
      .OUT_QL(out_ql), .ACT_SRC(act_src), .FAC_CFG(fac_cfg));
   srs_partner i_srs_partner (.en(en), .ql(ql), .bt_clk(bt_clk),
      .bt_ql(bt_ql), .ln_clk(ln_clk), .ln_s1(ln_s1));

   // Verdict and end of run
   task automatic report_and_stop();
      $display("Compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(string n, logic [31:0] s, logic [31:0] x);
      compares++;
      if (s !== x) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask : chk

   // One classic bus cycle, read data left in q
   task automatic wb(logic we, logic [7:0] ad, logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{1'b1, 1'b1, we, ad, 4'hf, d};
      // Ack and data taken as they stand at the rising edge
      do begin
         @(posedge clk);
         n++;
      end while (rsp.ack !== 1'b1 && n < 20);
      if (rsp.ack !== 1'b1) begin
         chk("ack", rsp.ack, 1);
         report_and_stop();
      end
      q = rsp.dat;
      req <= '0;
   endtask : wb

   // Bounded wait for a selection, then settle
   task automatic wt(logic [3:0] x, int m);
      int n;
      n = 0;
      while (act_src !== x && n < m) begin
         @(negedge clk);
         n++;
      end
      repeat (10) @(negedge clk);
      chk("act_src", act_src, x);
      if (act_src !== x) report_and_stop();
   endtask : wt

   function automatic logic [2:0] rk(logic [3:0] c);
      case (c)
         4'h2: return 3'h0;
         4'h0: return 3'h1;
         4'h4: return 3'h2;
         4'h8: return 3'h3;
         4'hb: return 3'h4;
         default: return 3'h7;
      endcase
   endfunction : rk

   // System clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      req = '0;
      en = 4'h0;
      ql = '0;
      fail_count = 0;
      compares = 0;
      void'($urandom(32'haaab));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("tx_s1", tx_s1[0], 8'h0b);
      chk("out_ql", out_ql, SRS_QL_SETS);
      chk("fac_cfg", fac_cfg, 32'hc8);
      wb(0, SRS_CTRL_OFS, 0);
      chk("ctrl", q, 32'h4);
      wb(0, SRS_FAC_OFS, 0);
      chk("fac", q, 32'h3c64);
      wb(0, SRS_REVT_OFS, 0);
      chk("revt", q, 32'h12c);
      wb(0, 8'h18, 0);
      chk("unmapped", q, 0);
      $display("Test reset done");
      wb(1, SRS_CTRL_OFS, 32'h1c);
      wb(1, SRS_NEREF_OFS, 32'h021);
      wb(1, SRS_OUTREF_OFS, 32'h002001);
      wb(1, SRS_REVT_OFS, 32'h1);
      en <= 4'hf;
      for (int i = 0; i < 16; i++) begin
         a = 4'(i);
         b = 4'($urandom_range(15, 0));
         @(posedge clk);
         ql <= {SRS_QL_PRC, SRS_QL_PRC, b, a};
         e = (rk(a) != 3'h7 && rk(a) <= rk(b)) ? 4'h1 :
            (rk(b) != 3'h7 ? 4'h2 : 4'h0);
         o = e == 4'h1 ? a : (e == 4'h2 ? b : SRS_QL_SETS);
         wt(e, 400);
         chk("out_ql", out_ql, o);
         chk("tx_s1", tx_s1[1], {4'h0, o});
      end
      $display("Test ranking done");
      @(posedge clk);
      ql <= 16'h2222;
      for (int i = 0; i < 6; i++) begin
         f = FV[i] | 32'($urandom_range(4, 0)) << 7;
         wb(1, SRS_FAC_OFS, f);
         repeat (20) @(negedge clk);
         chk("ais", out_ais, AV[i]);
         chk("fac_cfg", fac_cfg, {f[1:0], f[2], f[5:3], f[6], f[9:7]});
      end
      chk("out_src", out_src, 8'h21);
      chk("out_act", out_active, 2'h3);
      wb(1, SRS_FAC_OFS, 32'h3c65);
      repeat (20) @(negedge clk);
      chk("ssm_off", fac_cfg.ssm, 0);
      chk("fac_clk", fac_cfg, 32'h100);
      wb(1, SRS_CTRL_OFS, 32'h04);
      wt(0, 300);
      chk("out_act", out_active, 2'h0);
      $display("Test threshold done");
      wb(1, SRS_FAC_OFS, 32'h3c64);
      wb(1, SRS_NEREF_OFS, 32'h013);
      for (int m = 0; m < 3; m++) begin
         wb(1, SRS_CTRL_OFS, 32'h1c | m);
         wt(MV[m], 400);
      end
      chk("tx_s1", tx_s1[0], 8'h0f);
      chk("tx_s1", tx_s1[1], 8'h02);
      wb(1, SRS_FAC_OFS, 32'h3c66);
      wt(1, 300);
      wb(1, SRS_FAC_OFS, 32'h3c64);
      wt(3, 400);
      $display("Test modes done");
      wb(1, SRS_CTRL_OFS, 32'h1d);
      wb(1, SRS_NEREF_OFS, 32'h043);
      wb(1, SRS_REVT_OFS, 32'd40);
      en <= 4'hb;
      wt(4, 300);
      @(posedge clk);
      en <= 4'hf;
      repeat (150) @(negedge clk);
      chk("act_src", act_src, 4);
      wb(0, SRS_STAT_OFS, 0);
      chk("pend", q[10], 1);
      en <= 4'hb;
      repeat (350) @(negedge clk);
      chk("act_src", act_src, 4);
      wb(0, SRS_STAT_OFS, 0);
      chk("pend", q[10], 0);
      @(posedge clk);
      en <= 4'hf;
      repeat (300) @(negedge clk);
      chk("act_src", act_src, 4);
      wt(3, 400);
      $display("Test revert done");
      report_and_stop();
   end
endmodule : tb_top
